/* File: rtl/tcc_consts.vh */
// Register indices, field positions and reset values of the 16-bit timer
`ifndef TCC_CONSTS_VH
`define TCC_CONSTS_VH

// Register indices; byte address is four times the index
`define TCC_IDX_CTRL      8'h80
`define TCC_IDX_CFG       8'h81
`define TCC_IDX_FLAGS     8'h82
`define TCC_IDX_CNT_LO    8'h84
`define TCC_IDX_CNT_HI    8'h85
`define TCC_IDX_CMPA_LO   8'h86
`define TCC_IDX_CMPA_HI   8'h87
`define TCC_IDX_CMPB_LO   8'h88
`define TCC_IDX_CMPB_HI   8'h89
`define TCC_IDX_CAP_LO    8'h8A
`define TCC_IDX_CAP_HI    8'h8B
`define TCC_IDX_PINEN     8'hE2

// Control register fields
`define TCC_CTRL_WGM_LSB  0
`define TCC_CTRL_COMA_LSB 4
`define TCC_CTRL_COMB_LSB 6

// Configuration register fields
`define TCC_CFG_EDGE      0
`define TCC_CFG_COMPARATOR_CAPTURE_SELECT      1
`define TCC_CFG_CAPIE     2
`define TCC_CFG_FOCA      3
`define TCC_CFG_FOCB      4
`define TCC_CFG_OVFIE     5

// Flag register fields
`define TCC_FLG_CAP       0
`define TCC_FLG_OVF       1
`define TCC_FLG_MATA      2
`define TCC_FLG_MATB      3

// Waveform modes handled here
`define TCC_WGM_NORMAL    4'h0
`define TCC_WGM_CTC_A     4'h4
`define TCC_WGM_CTC_CAP   4'hC
`define TCC_WGM_W         4

// Compare output actions
`define TCC_COM_NONE      2'h0
`define TCC_COM_TOGGLE    2'h1
`define TCC_COM_CLEAR     2'h2
`define TCC_COM_SET       2'h3

// Reset values and bus answers
`define TCC_RST_BYTE      8'h00
`define TCC_RST_WORD      16'h0000
`define TCC_CNT_MAX       16'hFFFF
`define TCC_RESP_OKAY     2'h0
`define TCC_RESP_SLVERR   2'h2

`endif

/* File: rtl/tcc_timer16.v */
// 16-bit timer with capture, two compare units and AXI4-Lite registers
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "tcc_consts.vh"

module tcc_timer16 #(
    parameter ADDR_W = 12,
    parameter NCH    = 8
) (
    input  wire              aclk,
    input  wire              aresetn,
    input  wire              clk_en,
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output reg               s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output reg               s_axi_wready,
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output reg               s_axi_arready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    input  wire              capture_input_pin,
    input  wire              comparator_output,
    input  wire              capture_irq_ack,
    input  wire              overflow_irq_ack,
    output reg               capture_irq_ff,
    output reg               overflow_irq_ff,
    input  wire [1:0]        port_oc_value,
    input  wire [1:0]        port_oc_dir,
    output reg  [1:0]        oc_pin_out_ff,
    output reg  [1:0]        oc_pin_oe_ff,
    input  wire [NCH-1:0]    port_ch_value,
    input  wire [NCH-1:0]    port_ch_dir,
    output reg  [NCH-1:0]    ch_pin_out_ff,
    output reg  [NCH-1:0]    ch_pin_oe_ff
);

////////////////////////////////////////////////////////////////////////////////
// State

reg  [3:0]     wgm_ff;
reg  [1:0]     com_a_ff;
reg  [1:0]     com_b_ff;
reg            edge_rise_ff;
reg            comparator_capture_select_ff;
reg            capie_ff;
reg            ovfie_ff;
reg            cap_flag_ff;
reg            ovf_flag_ff;
reg            mat_a_flag_ff;
reg            mat_b_flag_ff;
reg  [15:0]    cnt_ff;
reg  [15:0]    cmpa_ff;
reg  [15:0]    cmpb_ff;
reg  [15:0]    cap_ff;
reg  [7:0]     temp_ff;
reg  [NCH-1:0] pinen_ff;
reg            block_ff;
reg            oc_a_ff;
reg            oc_b_ff;
reg  [2:0]     pin_sync_ff;
reg  [2:0]     cmp_sync_ff;
reg            src_lvl_ff;
reg  [7:0]     wr_idx_ff;
reg            wr_hi_ok_ff;
reg  [31:0]    wdata_ff;
reg            wstrb0_ff;

////////////////////////////////////////////////////////////////////////////////
// Combinational helpers

wire [7:0] rd_idx    = s_axi_araddr[9:2];
wire       rd_hi_ok  = (s_axi_araddr[ADDR_W-1:10] == {(ADDR_W-10){1'b0}});
wire       aw_have   = ~s_axi_awready;
wire       w_have    = ~s_axi_wready;
wire       do_wr     = aw_have & w_have & ~s_axi_bvalid;
wire       wr_en     = do_wr & wstrb0_ff & wr_hi_ok_ff;
wire [7:0] wbyte     = wdata_ff[7:0];
wire       rd_take   = s_axi_arvalid & s_axi_arready;

// Forcing only exists in the non-PWM modes
wire nonpwm = (wgm_ff == `TCC_WGM_NORMAL) || (wgm_ff == `TCC_WGM_CTC_A) ||
              (wgm_ff == `TCC_WGM_CTC_CAP);

wire wr_cnt   = wr_en && (wr_idx_ff == `TCC_IDX_CNT_LO);
wire wr_cfg   = wr_en && (wr_idx_ff == `TCC_IDX_CFG);
wire wr_flags = wr_en && (wr_idx_ff == `TCC_IDX_FLAGS);
wire force_a  = wr_cfg && wbyte[`TCC_CFG_FOCA] && nonpwm;
wire force_b  = wr_cfg && wbyte[`TCC_CFG_FOCB] && nonpwm;

// Compare every tick; a counter write blanks the next one
wire match_a = (cnt_ff == cmpa_ff) && !block_ff;
wire match_b = (cnt_ff == cmpb_ff) && !block_ff;

// Counting depends on waveform mode alone
reg  [15:0] cnt_next;
reg         ovf_event;
always @* begin
    cnt_next  = cnt_ff + 16'h0001;
    ovf_event = 1'b0;
    case (wgm_ff)
        `TCC_WGM_CTC_A: begin
            if (cnt_ff == cmpa_ff) begin
                cnt_next = `TCC_RST_WORD;
            end
        end
        `TCC_WGM_CTC_CAP: begin
            if (cnt_ff == cap_ff) begin
                cnt_next = `TCC_RST_WORD;
            end
        end
        `TCC_WGM_NORMAL: begin
            ovf_event = (cnt_ff == `TCC_CNT_MAX);
        end
        default: begin
            ovf_event = 1'b0;
        end
    endcase
end

// Pin action for one compare unit
function oc_action;
    input       cur;
    input [1:0] com;
    begin
        case (com)
            `TCC_COM_TOGGLE: oc_action = ~cur;
            `TCC_COM_CLEAR:  oc_action = 1'b0;
            `TCC_COM_SET:    oc_action = 1'b1;
            default:         oc_action = cur;
        endcase
    end
endfunction

wire oc_a_next = (match_a || force_a) ? oc_action(oc_a_ff, com_a_ff) : oc_a_ff;
wire oc_b_next = (match_b || force_b) ? oc_action(oc_b_ff, com_b_ff) : oc_b_ff;

// Capture edge detect; only second and third stages are looked at.
// Source mux sits after the synchronisers so a switch can itself capture.
wire src_s2  = comparator_capture_select_ff ? cmp_sync_ff[1] : pin_sync_ff[1];
wire src_s3  = comparator_capture_select_ff ? cmp_sync_ff[2] : pin_sync_ff[2];
wire agreed  = (src_s2 == src_s3);
wire src_chg = agreed && (src_s3 != src_lvl_ff);
// Capture is off while the capture register sets the top; compare
// mode bits play no part here.
wire cap_event = src_chg && (src_s3 == edge_rise_ff) &&
                 (wgm_ff != `TCC_WGM_CTC_CAP);

// Read data mux
reg [31:0] rd_word;
reg        rd_hit;
always @* begin
    rd_word = 32'h0000_0000;
    rd_hit  = rd_hi_ok;
    case (rd_idx)
        `TCC_IDX_CTRL:    rd_word[7:0] = {com_b_ff, com_a_ff, wgm_ff};
        `TCC_IDX_CFG:     rd_word[7:0] = {2'b00, ovfie_ff, 2'b00, capie_ff,
                                          comparator_capture_select_ff, edge_rise_ff};
        `TCC_IDX_FLAGS:   rd_word[7:0] = {4'h0, mat_b_flag_ff, mat_a_flag_ff,
                                          ovf_flag_ff, cap_flag_ff};
        `TCC_IDX_CNT_LO:  rd_word[7:0] = cnt_ff[7:0];
        `TCC_IDX_CMPA_LO: rd_word[7:0] = cmpa_ff[7:0];
        `TCC_IDX_CMPB_LO: rd_word[7:0] = cmpb_ff[7:0];
        `TCC_IDX_CAP_LO:  rd_word[7:0] = cap_ff[7:0];
        `TCC_IDX_CNT_HI,
        `TCC_IDX_CMPA_HI,
        `TCC_IDX_CMPB_HI,
        `TCC_IDX_CAP_HI:  rd_word[7:0] = temp_ff;
        `TCC_IDX_PINEN:   rd_word[7:0] = pinen_ff;
        default:          rd_hit = 1'b0;
    endcase
end

// High byte that a low-byte read parks in the shared temp
reg [7:0] rd_hi_byte;
reg       rd_lo;
always @* begin
    rd_hi_byte = temp_ff;
    rd_lo      = rd_take && rd_hi_ok;
    case (rd_idx)
        `TCC_IDX_CNT_LO:  rd_hi_byte = cnt_ff[15:8];
        `TCC_IDX_CMPA_LO: rd_hi_byte = cmpa_ff[15:8];
        `TCC_IDX_CMPB_LO: rd_hi_byte = cmpb_ff[15:8];
        `TCC_IDX_CAP_LO:  rd_hi_byte = cap_ff[15:8];
        default:          rd_lo = 1'b0;
    endcase
end

wire wr_hi = wr_en && ((wr_idx_ff == `TCC_IDX_CNT_HI) ||
             (wr_idx_ff == `TCC_IDX_CMPA_HI) ||
             (wr_idx_ff == `TCC_IDX_CMPB_HI) ||
             (wr_idx_ff == `TCC_IDX_CAP_HI));
wire wr_map = (wr_idx_ff == `TCC_IDX_CTRL) || (wr_idx_ff == `TCC_IDX_CFG) ||
              (wr_idx_ff == `TCC_IDX_FLAGS) ||
              (wr_idx_ff == `TCC_IDX_CNT_LO) ||
              (wr_idx_ff == `TCC_IDX_CMPA_LO) ||
              (wr_idx_ff == `TCC_IDX_CMPB_LO) ||
              (wr_idx_ff == `TCC_IDX_CAP_LO) ||
              (wr_idx_ff == `TCC_IDX_PINEN) ||
              (wr_idx_ff == `TCC_IDX_CNT_HI) ||
              (wr_idx_ff == `TCC_IDX_CMPA_HI) ||
              (wr_idx_ff == `TCC_IDX_CMPB_HI) ||
              (wr_idx_ff == `TCC_IDX_CAP_HI);
wire [15:0] wr_word = {temp_ff, wbyte};

////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite handshakes

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
        s_axi_bvalid  <= 1'b0;
        s_axi_bresp   <= `TCC_RESP_OKAY;
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b0;
        s_axi_rdata   <= 32'h0000_0000;
        s_axi_rresp   <= `TCC_RESP_OKAY;
        wr_idx_ff     <= `TCC_RST_BYTE;
        wr_hi_ok_ff   <= 1'b0;
        wdata_ff      <= 32'h0000_0000;
        wstrb0_ff     <= 1'b0;
    end else if (clk_en) begin
        if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            wr_idx_ff     <= s_axi_awaddr[9:2];
            wr_hi_ok_ff   <= (s_axi_awaddr[ADDR_W-1:10] ==
                              {(ADDR_W-10){1'b0}});
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            wdata_ff     <= s_axi_wdata;
            wstrb0_ff    <= s_axi_wstrb[0];
        end
        if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_map && wr_hi_ok_ff) ? `TCC_RESP_OKAY
                                                    : `TCC_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
        end
        if (rd_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_hit ? rd_word : 32'h0000_0000;
            s_axi_rresp   <= rd_hit ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Timer core and registers

always @(posedge aclk) begin
    if (!aresetn) begin
        wgm_ff        <= 4'h0;
        com_a_ff      <= `TCC_COM_NONE;
        com_b_ff      <= `TCC_COM_NONE;
        edge_rise_ff  <= 1'b1;
        comparator_capture_select_ff       <= 1'b0;
        capie_ff      <= 1'b0;
        ovfie_ff      <= 1'b0;
        cap_flag_ff   <= 1'b0;
        ovf_flag_ff   <= 1'b0;
        mat_a_flag_ff <= 1'b0;
        mat_b_flag_ff <= 1'b0;
        cnt_ff        <= `TCC_RST_WORD;
        cmpa_ff       <= `TCC_RST_WORD;
        cmpb_ff       <= `TCC_RST_WORD;
        cap_ff        <= `TCC_RST_WORD;
        temp_ff       <= `TCC_RST_BYTE;
        pinen_ff      <= {NCH{1'b0}};
        block_ff      <= 1'b0;
        oc_a_ff       <= 1'b0;
        oc_b_ff       <= 1'b0;
        pin_sync_ff   <= 3'b000;
        cmp_sync_ff   <= 3'b000;
        src_lvl_ff    <= 1'b0;
    end else if (clk_en) begin
        pin_sync_ff <= {pin_sync_ff[1:0], capture_input_pin};
        cmp_sync_ff <= {cmp_sync_ff[1:0], comparator_output};
        if (agreed) begin
            src_lvl_ff <= src_s3;
        end
        // Counter write wins over counting at any time
        if (wr_cnt) begin
            cnt_ff   <= wr_word;
            block_ff <= 1'b1;
        end else begin
            cnt_ff   <= cnt_next;
            block_ff <= 1'b0;
        end
        oc_a_ff <= oc_a_next;
        oc_b_ff <= oc_b_next;
        if (cap_event) begin
            cap_ff <= cnt_ff;
        end else if (wr_en && (wr_idx_ff == `TCC_IDX_CAP_LO) &&
                     (wgm_ff == `TCC_WGM_CTC_CAP)) begin
            cap_ff <= wr_word;
        end
        if (wr_en && (wr_idx_ff == `TCC_IDX_CMPA_LO)) begin
            cmpa_ff <= wr_word;
        end
        if (wr_en && (wr_idx_ff == `TCC_IDX_CMPB_LO)) begin
            cmpb_ff <= wr_word;
        end
        // Bus write to temp beats a read latch in the same cycle
        if (wr_hi) begin
            temp_ff <= wbyte;
        end else if (rd_lo) begin
            temp_ff <= rd_hi_byte;
        end
        if (wr_en && (wr_idx_ff == `TCC_IDX_CTRL)) begin
            wgm_ff   <= wbyte[`TCC_CTRL_WGM_LSB +: `TCC_WGM_W];
            com_a_ff <= wbyte[`TCC_CTRL_COMA_LSB +: 2];
            com_b_ff <= wbyte[`TCC_CTRL_COMB_LSB +: 2];
        end
        if (wr_cfg) begin
            edge_rise_ff <= wbyte[`TCC_CFG_EDGE];
            comparator_capture_select_ff      <= wbyte[`TCC_CFG_COMPARATOR_CAPTURE_SELECT];
            capie_ff     <= wbyte[`TCC_CFG_CAPIE];
            ovfie_ff     <= wbyte[`TCC_CFG_OVFIE];
        end
        if (wr_en && (wr_idx_ff == `TCC_IDX_PINEN)) begin
            pinen_ff <= wbyte[NCH-1:0];
        end
        // Sticky flags: a new event beats a clear in the same cycle
        cap_flag_ff   <= cap_event | (cap_flag_ff &
                         ~(wr_flags & wbyte[`TCC_FLG_CAP]) &
                         ~capture_irq_ack);
        ovf_flag_ff   <= ovf_event | (ovf_flag_ff &
                         ~(wr_flags & wbyte[`TCC_FLG_OVF]) &
                         ~overflow_irq_ack);
        mat_a_flag_ff <= match_a | (mat_a_flag_ff &
                         ~(wr_flags & wbyte[`TCC_FLG_MATA]));
        mat_b_flag_ff <= match_b | (mat_b_flag_ff &
                         ~(wr_flags & wbyte[`TCC_FLG_MATB]));
    end
end

////////////////////////////////////////////////////////////////////////////////
// Interrupt requests and pins, all registered

always @(posedge aclk) begin
    if (!aresetn) begin
        capture_irq_ff  <= 1'b0;
        overflow_irq_ff <= 1'b0;
        oc_pin_out_ff   <= 2'b00;
        oc_pin_oe_ff    <= 2'b00;
    end else if (clk_en) begin
        // One cycle behind the flag, so an ack can lag by one edge
        capture_irq_ff  <= cap_flag_ff & capie_ff;
        overflow_irq_ff <= ovf_flag_ff & ovfie_ff;
        oc_pin_out_ff[0] <= (com_a_ff != `TCC_COM_NONE) ? oc_a_ff
                                                         : port_oc_value[0];
        oc_pin_out_ff[1] <= (com_b_ff != `TCC_COM_NONE) ? oc_b_ff
                                                         : port_oc_value[1];
        oc_pin_oe_ff     <= port_oc_dir;
    end
end

// Even channels carry unit A, odd channels unit B
genvar gi;
generate
    for (gi = 0; gi < NCH; gi = gi + 1) begin : g_ch
        always @(posedge aclk) begin
            if (!aresetn) begin
                ch_pin_out_ff[gi] <= 1'b0;
                ch_pin_oe_ff[gi]  <= 1'b0;
            end else if (clk_en) begin
                if (pinen_ff[gi]) begin
                    ch_pin_out_ff[gi] <= (gi % 2 == 1) ? oc_b_ff : oc_a_ff;
                    ch_pin_oe_ff[gi]  <= 1'b1;
                end else begin
                    ch_pin_out_ff[gi] <= port_ch_value[gi];
                    ch_pin_oe_ff[gi]  <= port_ch_dir[gi];
                end
            end
        end
    end
endgenerate

endmodule
`default_nettype wire

/* File: verif/tcc_trig_src.sv */
// Far-side model driving the capture pin and comparator output
`timescale 1ns/1ns
`default_nettype none
module tcc_trig_src (
    input  wire logic [1:0] lvl_req,
    input  wire logic       aclk,
    output var  logic       capture_input_pin,
    output var  logic       comparator_output
);
    // Levels move just after an edge, unrelated to bus traffic
    initial begin
        capture_input_pin = 1'b0;
        comparator_output = 1'b0;
    end
    always @(posedge aclk) begin
        capture_input_pin <= lvl_req[0];
        comparator_output <= lvl_req[1];
    end
endmodule
`default_nettype wire

/* File: verif/tcc_timer16_asserts.sv */
// Checker for bus handshakes and pin behaviour of the timer
`timescale 1ns/1ns
`default_nettype none
module tcc_timer16_asserts #(
    parameter NCH = 8
) (
    input wire logic           aclk,
    input wire logic           aresetn,
    input wire logic           clk_en,
    input wire logic           s_axi_awvalid,
    input wire logic           s_axi_awready,
    input wire logic           s_axi_wvalid,
    input wire logic           s_axi_wready,
    input wire logic [1:0]     s_axi_bresp,
    input wire logic           s_axi_bvalid,
    input wire logic           s_axi_bready,
    input wire logic           s_axi_arvalid,
    input wire logic           s_axi_arready,
    input wire logic [31:0]    s_axi_rdata,
    input wire logic [1:0]     s_axi_rresp,
    input wire logic           s_axi_rvalid,
    input wire logic           s_axi_rready,
    input wire logic           capture_irq_ff,
    input wire logic [1:0]     port_oc_dir,
    input wire logic [1:0]     oc_pin_out_ff,
    input wire logic [1:0]     oc_pin_oe_ff,
    input wire logic [NCH-1:0] ch_pin_out_ff
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr_taken;
        clk_en && s_axi_awvalid && s_axi_awready
            && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_wr_answer;
        !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    chk_wr_answer: assert property (s_wr_taken |=> s_wr_answer)
        else $error("write response late or readies not dropped");
    chk_b_release: assert property (clk_en && s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("write response not released");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_r_answer: assert property (clk_en && s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer changed before taken");
    chk_err_data: assert property (s_axi_rvalid && s_axi_rresp == 2'h2
        |-> s_axi_rdata == 32'h0000_0000)
        else $error("error read carries data");
    chk_rst_pins: assert property ($rose(aresetn) |-> oc_pin_out_ff == 2'h0
        && ch_pin_out_ff == '0 && !capture_irq_ff)
        else $error("pins not cleared by reset");
    chk_oe_dir: assert property (clk_en |=> oc_pin_oe_ff == $past(port_oc_dir))
        else $error("pin direction not from port");
endmodule
////////////////////////////////////////////////////////////////////////////
bind tcc_timer16 tcc_timer16_asserts #(.NCH(NCH)) u_chk (.aclk(aclk),
    .aresetn(aresetn), .clk_en(clk_en), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .capture_irq_ff(capture_irq_ff), .port_oc_dir(port_oc_dir),
    .oc_pin_out_ff(oc_pin_out_ff), .oc_pin_oe_ff(oc_pin_oe_ff),
    .ch_pin_out_ff(ch_pin_out_ff));
`default_nettype wire

/* File: verif/tcc_timer16_tb.sv */
// Self-checking bench for the 16-bit capture/compare timer
`timescale 1ns/1ns
`default_nettype none
`include "tcc_consts.vh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end
module tcc_timer16_tb;
    logic        aclk, aresetn, capture_irq_ack, overflow_irq_ack;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, capture_input_pin;
    logic        comparator_output, capture_irq_ff, overflow_irq_ff;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rrsp, lvl_req;
    logic [1:0]  port_oc_value, port_oc_dir, oc_pin_out_ff, oc_pin_oe_ff;
    logic [7:0]  port_ch_value, port_ch_dir, ch_pin_out_ff, ch_pin_oe_ff;
    logic [7:0]  rdat;
    logic [15:0] r16;
    int          num_errors, n_compared;
    tcc_timer16 dut (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .capture_input_pin(capture_input_pin),
        .comparator_output(comparator_output),
        .capture_irq_ack(capture_irq_ack),
        .overflow_irq_ack(overflow_irq_ack),
        .capture_irq_ff(capture_irq_ff), .overflow_irq_ff(overflow_irq_ff),
        .port_oc_value(port_oc_value), .port_oc_dir(port_oc_dir),
        .oc_pin_out_ff(oc_pin_out_ff), .oc_pin_oe_ff(oc_pin_oe_ff),
        .port_ch_value(port_ch_value), .port_ch_dir(port_ch_dir),
        .ch_pin_out_ff(ch_pin_out_ff), .ch_pin_oe_ff(ch_pin_oe_ff));
    tcc_trig_src u_src (.lvl_req(lvl_req), .aclk(aclk),
        .capture_input_pin(capture_input_pin),
        .comparator_output(comparator_output));
    ////////////////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic bus_to(input int n);
        if (n >= 60) begin
            num_errors++;
            summarize();
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= {2'b00, idx, 2'b00};
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        bus_to(n);
    endtask
    task automatic rd(input logic [7:0] idx);
        int n;
        @(posedge aclk);
        s_axi_araddr <= {2'b00, idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        rdat = s_axi_rdata[7:0];
        rrsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        bus_to(n);
    endtask
    // High byte first on write, low byte first on read
    task automatic wr16(input logic [7:0] lo, input logic [15:0] v);
        wr(lo + 8'h01, v[15:8]);
        wr(lo, v[7:0]);
    endtask
    task automatic rd16(input logic [7:0] lo);
        rd(lo);
        r16[7:0] = rdat;
        rd(lo + 8'h01);
        r16[15:8] = rdat;
    endtask
    task automatic wait_oc(input logic want);
        int n;
        for (n = 0; n < 60 && oc_pin_out_ff[0] !== want; n++) @(posedge aclk);
        `CHK(oc_pin_out_ff[0], want)
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset_vals;
        rd(`TCC_IDX_PINEN);
        `CHK(rdat, 8'h00)
        rd(`TCC_IDX_CFG);
        `CHK(rdat, 8'h01)
        rd(8'h10);
        `CHK(rrsp, 2'h2)
    endtask
    task automatic t_overflow;
        wr(`TCC_IDX_FLAGS, 8'h0F);
        wr(`TCC_IDX_CFG, 8'h21);
        wr16(`TCC_IDX_CNT_LO, 16'hFFF0);
        wt(30);
        rd(`TCC_IDX_FLAGS);
        `CHK(rdat[1], 1'b1)
        `CHK(overflow_irq_ff, 1'b1)
        overflow_irq_ack <= 1'b1;
        @(posedge aclk);
        overflow_irq_ack <= 1'b0;
        wt(3);
        `CHK(overflow_irq_ff, 1'b0)
        rd16(`TCC_IDX_CNT_LO);
        `CHK(r16 < 16'h0040, 1'b1)
    endtask
    task automatic t_capture;
        wr16(`TCC_IDX_CNT_LO, 16'h1234);
        wr(`TCC_IDX_FLAGS, 8'h01);
        lvl_req[0] <= 1'b1;
        wt(10);
        rd(`TCC_IDX_FLAGS);
        `CHK(rdat[0], 1'b1)
        rd16(`TCC_IDX_CAP_LO);
        `CHK(r16[15:8], 8'h12)
        wr16(`TCC_IDX_CAP_LO, 16'hABCD);
        rd16(`TCC_IDX_CAP_LO);
        `CHK(r16[15:8], 8'h12)
        wr(`TCC_IDX_FLAGS, 8'h01);
        rd(`TCC_IDX_FLAGS);
        `CHK(rdat[0], 1'b0)
        lvl_req[0] <= 1'b0;
        wt(10);
        rd(`TCC_IDX_FLAGS);
        `CHK(rdat[0], 1'b0)
    endtask
    task automatic t_source;
        wr(`TCC_IDX_CFG, 8'h07);
        wr(`TCC_IDX_FLAGS, 8'h01);
        lvl_req[0] <= 1'b1;
        wt(10);
        rd(`TCC_IDX_FLAGS);
        `CHK(rdat[0], 1'b0)
        lvl_req[1] <= 1'b1;
        wt(10);
        `CHK(capture_irq_ff, 1'b1)
        capture_irq_ack <= 1'b1;
        @(posedge aclk);
        capture_irq_ack <= 1'b0;
        wt(3);
        `CHK(capture_irq_ff, 1'b0)
        wr(`TCC_IDX_CFG, 8'h01);
        lvl_req <= 2'b00;
    endtask
    task automatic t_ctc;
        logic v;
        wr16(`TCC_IDX_CMPA_LO, 16'h0010);
        wr(`TCC_IDX_CTRL, 8'h14);
        wr16(`TCC_IDX_CNT_LO, 16'h0000);
        wr(`TCC_IDX_FLAGS, 8'h04);
        repeat (4) begin
            rd16(`TCC_IDX_CNT_LO);
            `CHK(r16 <= 16'h0010, 1'b1)
        end
        rd(`TCC_IDX_FLAGS);
        `CHK(rdat[2], 1'b1)
        v = oc_pin_out_ff[0];
        wait_oc(!v);
        wr(`TCC_IDX_CTRL, 8'h04);
        wt(3);
        `CHK(oc_pin_out_ff[0], port_oc_value[0])
    endtask
    task automatic t_force_chan;
        wr(`TCC_IDX_CTRL, 8'h30);
        wr16(`TCC_IDX_CNT_LO, 16'h0100);
        wr(`TCC_IDX_CFG, 8'h09);
        wait_oc(1'b1);
        wr(`TCC_IDX_CTRL, 8'h20);
        wr(`TCC_IDX_CFG, 8'h09);
        wait_oc(1'b0);
        port_ch_value <= 8'hFF;
        port_ch_dir <= 8'h00;
        wr(`TCC_IDX_PINEN, 8'h01);
        wt(3);
        rd(`TCC_IDX_PINEN);
        `CHK(rdat, 8'h01)
        `CHK(ch_pin_out_ff[1:0], 2'b10)
        `CHK(ch_pin_oe_ff[1:0], 2'b01)
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, capture_irq_ack, lvl_req} = '0;
        overflow_irq_ack = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'h1;
        {port_oc_value, port_oc_dir} = 4'b1011;
        {port_ch_value, port_ch_dir} = 16'hA50F;
        num_errors = 0;
        n_compared = 0;
        repeat (2) begin
            aresetn <= 1'b0;
            wt(4);
            aresetn <= 1'b1;
            wt(2);
        end
        t_reset_vals();
        t_overflow();
        t_capture();
        t_source();
        t_ctc();
        t_force_chan();
        summarize();
    end
endmodule
`default_nettype wire
